// ---- include/pamc_pkg.sv ----
/*
 * Constants, command codes, feature codes, register field positions and
 * timeout figures for the power, acoustic and maximum-address command handler.
 * Assumes a task-file front end that hands over a whole command block with a
 * one-cycle strobe and reads back the result registers.
 */
package pamc_pkg;
    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
    localparam logic [7:0] CMD_SET_MAX = 8'hF9;
    localparam logic [7:0] CMD_READ_NATIVE_MAX = 8'hF8;
    localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;

    localparam logic [7:0] FEAT_PWR_ON = 8'h05;
    localparam logic [7:0] FEAT_PWR_OFF = 8'h85;
    localparam logic [7:0] FEAT_ACU_ON = 8'h42;
    localparam logic [7:0] FEAT_ACU_OFF = 8'hC2;
    localparam logic [7:0] FEAT_OFFSET_ON = 8'h09;
    localparam logic [7:0] FEAT_OFFSET_OFF = 8'h89;
    localparam logic [7:0] FEAT_REVERT_OFF = 8'h66;
    localparam logic [7:0] FEAT_REVERT_ON = 8'hCC;
    localparam logic [7:0] FEAT_SEC_PASSWORD = 8'h01;
    localparam logic [7:0] FEAT_SEC_LOCK = 8'h02;
    localparam logic [7:0] FEAT_SEC_UNLOCK = 8'h03;
    localparam logic [7:0] FEAT_SEC_FREEZE = 8'h04;

    localparam logic [7:0] LVL_MAX = 8'hFF;
    localparam logic [7:0] LVL_ZERO = 8'h00;
    localparam logic [7:0] LVL_NORMAL_LO = 8'hC0;
    localparam logic [7:0] LVL_IDLE_LO = 8'h80;
    localparam logic [7:0] LVL_STBY_HI_LO = 8'h40;

    localparam logic [12:0] IDLE_STEP_S = 13'h0005;
    localparam logic [12:0] IDLE_BASE_S = 13'h0078;
    localparam logic [12:0] STBY_STEP_S = 13'h003C;
    localparam logic [12:0] STBY_BASE_S = 13'h0258;

    localparam logic [27:0] LBA28_LIMIT = 28'hFFFFFFF;

    localparam int ERR_ABORT_BIT = 2;
    localparam int STS_ERR_BIT = 0;
    localparam int STS_SEEK_BIT = 4;
    localparam int STS_READY_BIT = 6;
    localparam int DEV_LBA_BIT = 6;

    typedef enum logic [1:0] {PAMC_NORMAL_IDLE, PAMC_LOW_IDLE, PAMC_LOW_STANDBY} pamc_pwr_t;
    typedef enum logic [1:0] {PAMC_UNLOCKED, PAMC_LOCKED, PAMC_FROZEN} pamc_sec_t;
endpackage

// ---- src/pamc_cmd.sv ----
/*
 * Command handler for set-features power and acoustic levels and the
 * maximum-address command with its security dispatch.
 * Assumes the task-file front end presents the command block with cmd_valid
 * held for one cycle, and carries power-on, hardware and soft reset events
 * as synchronous one-cycle pulses on the core clock.
 */
module pamc_cmd #(
    parameter logic [47:0] NATIVE_MAX = 48'h0000_1D1C_5970,
    parameter logic [15:0] CHS_MAX_CYL = 16'h3FFF,
    parameter logic [7:0] CHS_MAX_SECT = 8'h3F,
    parameter logic [3:0] CHS_MAX_HEAD = 4'hF,
    parameter bit LBA48 = 1'b1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // reset events
    input wire logic por_pulse,
    input wire logic hard_rst_pulse,
    input wire logic soft_rst_pulse,
    // command block in
    input wire logic cmd_valid,
    input wire logic [7:0] command_code,
    input wire logic [7:0] feature_in,
    input wire logic [7:0] sect_count_in,
    input wire logic [7:0] sect_num_in,
    input wire logic [7:0] cyl_low_in,
    input wire logic [7:0] cyl_high_in,
    input wire logic [7:0] device_head_select,
    // access check
    input wire logic [47:0] access_lba,
    output logic access_beyond_max,
    // result registers
    output logic cmd_done,
    output logic [7:0] error_flags,
    output logic [7:0] drive_status,
    output logic [7:0] sect_num_out,
    output logic [7:0] cyl_low_out,
    output logic [7:0] cyl_high_out,
    output logic [3:0] head_out,
    // power and acoustic state
    output logic [1:0] power_saving_control,
    output logic [12:0] low_power_idle_timeout,
    output logic [12:0] low_speed_standby_timeout,
    output logic acoustic_seek_control_en,
    output logic acoustic_seek_control_quiet,
    // identify words and security dispatch
    output logic [27:0] ident_max_28,
    output logic [47:0] ident_max_48,
    output logic [2:0] sec_op_pulse
);
    typedef struct packed {
        logic done;
        logic [7:0] err;
        logic [7:0] sts;
        logic [7:0] sn;
        logic [7:0] cl;
        logic [7:0] ch;
        logic [3:0] hd;
        logic beyond;
        pamc_pkg::pamc_pwr_t pwr;
        logic [12:0] lpi;
        logic [12:0] lss;
        logic lpi_set;
        logic acu_en;
        logic acu_quiet;
        logic revert_off;
        logic offset_mode;
        logic prev_native;
        logic nv_used;
        logic ext_hpa;
        pamc_pkg::pamc_sec_t sec;
        logic [47:0] max_vol;
        logic [47:0] max_nv;
        logic vol_valid;
        logic [27:0] id28;
        logic [47:0] id48;
        logic [2:0] secop;
    } pamc_state_t;

    pamc_state_t s_q, s_d;
    logic [7:0] lvl;
    logic [27:0] req28;
    logic [47:0] max_now;

    assign lvl = sect_count_in;
    assign req28 = {device_head_select[3:0], cyl_high_in, cyl_low_in, sect_num_in};
    assign max_now = s_q.vol_valid ? s_q.max_vol : s_q.max_nv;

    always_comb begin
        logic abort;
        logic [7:0] off;
        logic [47:0] newmax;
        abort = 1'b0;
        off = 8'h00;
        newmax = '0;
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.secop = 3'b000;
        // =====================================================================
        // access window check
        s_d.beyond = access_lba > max_now;
        // =====================================================================
        // reset events
        if (por_pulse || hard_rst_pulse || (soft_rst_pulse && !s_q.revert_off)) begin
            s_d.pwr = pamc_pkg::PAMC_NORMAL_IDLE;
            s_d.lpi = pamc_pkg::IDLE_BASE_S;
            s_d.lss = '0;
            s_d.lpi_set = 1'b0;
        end
        if (por_pulse || hard_rst_pulse) begin
            s_d.nv_used = 1'b0;
            s_d.revert_off = 1'b1;
            s_d.sec = pamc_pkg::PAMC_UNLOCKED;
        end
        if (por_pulse) begin
            s_d.vol_valid = 1'b0;
            s_d.offset_mode = 1'b0;
            // identify words fall back to the persistent maximum
            s_d.id28 = (s_q.max_nv > {20'h00000, pamc_pkg::LBA28_LIMIT})
                ? pamc_pkg::LBA28_LIMIT : s_q.max_nv[27:0];
            if (LBA48) begin
                s_d.id48 = s_q.max_nv;
            end
        end
        // =====================================================================
        // command decode
        if (cmd_valid) begin
            s_d.done = 1'b1;
            s_d.prev_native = (command_code == pamc_pkg::CMD_READ_NATIVE_MAX);
            unique case (command_code)
                pamc_pkg::CMD_SET_FEATURES: begin
                    unique case (feature_in)
                        pamc_pkg::FEAT_PWR_ON: begin
                            if (lvl == pamc_pkg::LVL_MAX || lvl == pamc_pkg::LVL_ZERO) begin
                                abort = 1'b1;
                            end else if (lvl >= pamc_pkg::LVL_NORMAL_LO) begin
                                s_d.pwr = pamc_pkg::PAMC_NORMAL_IDLE;
                                s_d.lpi_set = 1'b0;
                            end else if (lvl >= pamc_pkg::LVL_IDLE_LO) begin
                                off = lvl - pamc_pkg::LVL_IDLE_LO;
                                s_d.pwr = pamc_pkg::PAMC_LOW_IDLE;
                                s_d.lpi = 13'({5'h00, off} * pamc_pkg::IDLE_STEP_S
                                    + pamc_pkg::IDLE_BASE_S);
                                s_d.lss = '0;
                                s_d.lpi_set = 1'b1;
                            end else begin
                                s_d.pwr = pamc_pkg::PAMC_LOW_STANDBY;
                                if (!s_q.lpi_set) begin
                                    s_d.lpi = pamc_pkg::IDLE_BASE_S;
                                end
                                s_d.lpi_set = 1'b1;
                                if (lvl >= pamc_pkg::LVL_STBY_HI_LO) begin
                                    off = lvl - pamc_pkg::LVL_STBY_HI_LO;
                                    s_d.lss = 13'({5'h00, off} * pamc_pkg::STBY_STEP_S
                                        + pamc_pkg::STBY_BASE_S);
                                end else begin
                                    s_d.lss = pamc_pkg::STBY_BASE_S;
                                end
                            end
                        end
                        pamc_pkg::FEAT_PWR_OFF: begin
                            s_d.pwr = pamc_pkg::PAMC_NORMAL_IDLE;
                            s_d.lpi_set = 1'b0;
                        end
                        pamc_pkg::FEAT_ACU_ON: begin
                            if (lvl == pamc_pkg::LVL_MAX || lvl < pamc_pkg::LVL_IDLE_LO) begin
                                abort = 1'b1;
                            end else begin
                                s_d.acu_en = 1'b1;
                                s_d.acu_quiet = lvl < pamc_pkg::LVL_NORMAL_LO;
                            end
                        end
                        pamc_pkg::FEAT_ACU_OFF: s_d.acu_en = 1'b0;
                        pamc_pkg::FEAT_OFFSET_ON: s_d.offset_mode = 1'b1;
                        pamc_pkg::FEAT_OFFSET_OFF: s_d.offset_mode = 1'b0;
                        pamc_pkg::FEAT_REVERT_OFF: s_d.revert_off = 1'b1;
                        pamc_pkg::FEAT_REVERT_ON: s_d.revert_off = 1'b0;
                        default: abort = 1'b1;
                    endcase
                end
                pamc_pkg::CMD_SET_MAX_EXT: s_d.ext_hpa = 1'b1;
                pamc_pkg::CMD_SET_MAX: begin
                    if (s_q.prev_native) begin
                        if (s_q.sec != pamc_pkg::PAMC_UNLOCKED) begin
                            abort = 1'b1;
                        end else if (s_q.ext_hpa) begin
                            abort = 1'b1;
                        end else if (lvl[0] && (s_q.offset_mode || s_q.nv_used)) begin
                            abort = 1'b1;
                        end else begin
                            if (device_head_select[pamc_pkg::DEV_LBA_BIT]) begin
                                newmax = {20'h00000, req28};
                            end else begin
                                newmax = {24'h000000, cyl_high_in, cyl_low_in, 8'h00};
                            end
                            if (newmax > NATIVE_MAX) begin
                                abort = 1'b1;
                            end else begin
                                if (req28 == pamc_pkg::LBA28_LIMIT
                                    && NATIVE_MAX > {20'h00000, pamc_pkg::LBA28_LIMIT}) begin
                                    newmax = NATIVE_MAX;
                                end
                                s_d.id28 = (newmax > {20'h00000, pamc_pkg::LBA28_LIMIT})
                                    ? pamc_pkg::LBA28_LIMIT : newmax[27:0];
                                if (LBA48) begin
                                    s_d.id48 = newmax;
                                end
                                if (lvl[0]) begin
                                    s_d.max_nv = newmax;
                                    s_d.nv_used = 1'b1;
                                    s_d.vol_valid = 1'b0;
                                end else begin
                                    s_d.max_vol = newmax;
                                    s_d.vol_valid = 1'b1;
                                end
                                if (device_head_select[pamc_pkg::DEV_LBA_BIT]) begin
                                    s_d.sn = newmax[7:0];
                                    s_d.cl = newmax[15:8];
                                    s_d.ch = newmax[23:16];
                                    s_d.hd = newmax[27:24];
                                end else begin
                                    s_d.sn = CHS_MAX_SECT;
                                    s_d.cl = newmax[15:8];
                                    s_d.ch = newmax[23:16];
                                    s_d.hd = CHS_MAX_HEAD;
                                end
                            end
                        end
                    end else begin
                        unique case (feature_in)
                            pamc_pkg::FEAT_SEC_PASSWORD: s_d.secop = 3'b001;
                            pamc_pkg::FEAT_SEC_LOCK: begin
                                s_d.secop = 3'b010;
                                if (s_q.sec == pamc_pkg::PAMC_UNLOCKED) begin
                                    s_d.sec = pamc_pkg::PAMC_LOCKED;
                                end
                            end
                            pamc_pkg::FEAT_SEC_UNLOCK: s_d.secop = 3'b011;
                            pamc_pkg::FEAT_SEC_FREEZE: begin
                                s_d.secop = 3'b100;
                                s_d.sec = pamc_pkg::PAMC_FROZEN;
                            end
                            default: abort = 1'b1;
                        endcase
                    end
                end
                default: ;
            endcase
            s_d.err = 8'h00;
            s_d.err[pamc_pkg::ERR_ABORT_BIT] = abort;
            s_d.sts = 8'h00;
            s_d.sts[pamc_pkg::STS_READY_BIT] = 1'b1;
            s_d.sts[pamc_pkg::STS_SEEK_BIT] = 1'b1;
            s_d.sts[pamc_pkg::STS_ERR_BIT] = abort;
        end
        if (s_d.sec != pamc_pkg::PAMC_FROZEN && s_q.sec == pamc_pkg::PAMC_LOCKED
            && s_d.secop == 3'b011) begin
            s_d.sec = pamc_pkg::PAMC_UNLOCKED;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.lpi <= pamc_pkg::IDLE_BASE_S;
            s_q.revert_off <= 1'b1;
            s_q.max_nv <= NATIVE_MAX;
            s_q.id28 <= (NATIVE_MAX > {20'h00000, pamc_pkg::LBA28_LIMIT})
                ? pamc_pkg::LBA28_LIMIT : NATIVE_MAX[27:0];
            s_q.id48 <= NATIVE_MAX;
            s_q.sts <= 8'h50;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================================
    // outputs
    assign cmd_done = s_q.done;
    assign error_flags = s_q.err;
    assign drive_status = s_q.sts;
    assign sect_num_out = s_q.sn;
    assign cyl_low_out = s_q.cl;
    assign cyl_high_out = s_q.ch;
    assign head_out = s_q.hd;
    assign access_beyond_max = s_q.beyond;
    assign power_saving_control = s_q.pwr;
    assign low_power_idle_timeout = s_q.lpi;
    assign low_speed_standby_timeout = s_q.lss;
    assign acoustic_seek_control_en = s_q.acu_en;
    assign acoustic_seek_control_quiet = s_q.acu_quiet;
    assign ident_max_28 = s_q.id28;
    assign ident_max_48 = s_q.id48;
    assign sec_op_pulse = s_q.secop;
endmodule

// ---- tb/pamc_monitor.sv ----
/*
 * Port checker for the command handler, bound into pamc_cmd.
 * Assumes one clock domain and the asynchronous active-low reset.
 */
module pamc_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // reset events
    input wire logic por_pulse,
    input wire logic hard_rst_pulse,
    input wire logic soft_rst_pulse,
    // command block and access
    input wire logic cmd_valid,
    input wire logic [7:0] command_code,
    input wire logic [7:0] feature_in,
    input wire logic [7:0] sect_count_in,
    input wire logic [47:0] access_lba,
    // results
    input wire logic access_beyond_max,
    input wire logic cmd_done,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] drive_status,
    input wire logic [1:0] power_saving_control,
    input wire logic [12:0] low_speed_standby_timeout,
    input wire logic [12:0] low_power_idle_timeout,
    input wire logic acoustic_seek_control_en,
    input wire logic acoustic_seek_control_quiet,
    input wire logic [47:0] ident_max_48,
    input wire logic [2:0] sec_op_pulse
);
    // ====================
    // helpers
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic pm_on;
    logic sk_on;
    logic evt;
    assign pm_on = cmd_valid && command_code == 8'hEF && feature_in == 8'h05;
    assign sk_on = cmd_valid && command_code == 8'hEF && feature_in == 8'h42;
    assign evt = por_pulse || hard_rst_pulse || soft_rst_pulse;
    // ====================
    // assertions
    done_timing_a: assert property (cmd_valid |=> cmd_done)
        else $error("cmd_done missing after command");
    done_cause_a: assert property (!cmd_valid |=> !cmd_done)
        else $error("cmd_done without command");
    abort_pair_a: assert property (cmd_done |-> error_flags[2] == drive_status[0])
        else $error("abort and error status disagree");
    pwr_abort_a: assert property (pm_on && (sect_count_in == 8'hFF || sect_count_in == 8'h00)
        |=> error_flags[2] && drive_status[0]) else $error("power level not aborted");
    idle_time_a: assert property (pm_on && sect_count_in[7:6] == 2'b10 |=>
        power_saving_control == 2'h1 && low_power_idle_timeout ==
        {7'h00, $past(sect_count_in[5:0])} * 13'h0005 + 13'h0078) else $error("idle time wrong");
    stby_time_a: assert property (pm_on && sect_count_in[7:6] == 2'b01 |=>
        power_saving_control == 2'h2 && low_speed_standby_timeout ==
        {7'h00, $past(sect_count_in[5:0])} * 13'h003C + 13'h0258) else $error("standby time wrong");
    stby_fixed_a: assert property (pm_on && sect_count_in[7:6] == 2'b00 && sect_count_in != 8'h00
        |=> low_speed_standby_timeout == 13'h0258) else $error("fixed standby time wrong");
    pwr_off_a: assert property (cmd_valid && command_code == 8'hEF && feature_in == 8'h85
        |=> power_saving_control == 2'h0) else $error("power off not normal idle");
    seek_abort_a: assert property (sk_on && (!sect_count_in[7] || sect_count_in == 8'hFF)
        |=> error_flags[2]) else $error("acoustic level not aborted");
    seek_hold_a: assert property (evt && !cmd_valid |=> $stable(acoustic_seek_control_en)
        && $stable(acoustic_seek_control_quiet)) else $error("acoustic state lost on reset");
    beyond_max_a: assert property (!cmd_valid && !evt && access_lba > ident_max_48
        |=> access_beyond_max) else $error("access beyond max not flagged");
    // ====================
    // covers
    cover property (pm_on ##1 power_saving_control == 2'h2);
    cover property (cmd_done && error_flags[2]);
    cover property (sec_op_pulse == 3'h2);
    cover property (access_beyond_max);
endmodule

bind pamc_cmd pamc_monitor mon (.core_clk, .rst_n, .por_pulse, .hard_rst_pulse,
    .soft_rst_pulse, .cmd_valid, .command_code, .feature_in, .sect_count_in, .access_lba,
    .access_beyond_max, .cmd_done, .error_flags, .drive_status, .power_saving_control,
    .low_speed_standby_timeout, .low_power_idle_timeout, .acoustic_seek_control_en,
    .acoustic_seek_control_quiet, .ident_max_48, .sec_op_pulse);

// ---- tb/pamc_host.sv ----
/*
 * Host controller model: writes one command block per issue call.
 * Assumes the handler answers with a cmd_done pulse one cycle later.
 */
module pamc_host (
    // clock and answer
    input wire logic core_clk,
    input wire logic cmd_done,
    // command block
    output logic cmd_valid,
    output logic [7:0] command_code,
    output logic [7:0] feature_in,
    output logic [7:0] sect_count_in,
    output logic [7:0] sect_num_in,
    output logic [7:0] cyl_low_in,
    output logic [7:0] cyl_high_in,
    output logic [7:0] device_head_select
);
    timeunit 1ns;
    timeprecision 1ns;
    // set by the bench for a geometry-addressed command block
    bit chs = 1'b0;
    initial begin
        cmd_valid = 1'b0;
        {command_code, feature_in, sect_count_in, sect_num_in} = 32'h0;
        {cyl_low_in, cyl_high_in, device_head_select} = 24'h0;
    end
    task automatic issue(input logic [7:0] c, f, n, input logic [27:0] a, output logic ok);
        int k;
        @(posedge core_clk) #1;
        command_code = c;
        feature_in = f;
        sect_count_in = n;
        {device_head_select[3:0], cyl_high_in, cyl_low_in, sect_num_in} = a;
        device_head_select[7:4] = chs ? 4'hA : 4'hE;
        cmd_valid = 1'b1;
        @(posedge core_clk) #1;
        cmd_valid = 1'b0;
        // released block lines show the inverse, never the old value
        {command_code, feature_in, sect_count_in, sect_num_in} =
            ~{command_code, feature_in, sect_count_in, sect_num_in};
        {cyl_low_in, cyl_high_in, device_head_select} =
            ~{cyl_low_in, cyl_high_in, device_head_select};
        k = 0;
        while (cmd_done !== 1'b1 && k < 4) begin
            @(posedge core_clk) #1;
            k++;
        end
        ok = (cmd_done === 1'b1);
    endtask
endmodule

// ---- tb/tb_top.sv ----
/*
 * Self-checking bench for the command handler.
 * Assumes pamc_host as command source and the bound port checker.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [47:0] NMAX = 48'h0000_1D1C_5970;
    logic core_clk, rst_n, por_pulse, hard_rst_pulse, soft_rst_pulse, cmd_valid, cmd_done;
    logic [7:0] command_code, feature_in, sect_count_in, sect_num_in, cyl_low_in, cyl_high_in;
    logic [7:0] device_head_select, error_flags, drive_status, sect_num_out, cyl_low_out;
    logic [7:0] cyl_high_out;
    logic [3:0] head_out;
    logic [1:0] power_saving_control;
    logic [12:0] low_power_idle_timeout, low_speed_standby_timeout;
    logic acoustic_seek_control_en, acoustic_seek_control_quiet, access_beyond_max;
    logic [27:0] ident_max_28;
    logic [47:0] ident_max_48, access_lba;
    logic [2:0] sec_op_pulse;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    // ====================
    // instances
    pamc_cmd #(.NATIVE_MAX(NMAX)) dut (.core_clk, .rst_n, .por_pulse, .hard_rst_pulse,
        .soft_rst_pulse, .cmd_valid, .command_code, .feature_in, .sect_count_in, .sect_num_in,
        .cyl_low_in, .cyl_high_in, .device_head_select, .access_lba, .access_beyond_max,
        .cmd_done, .error_flags, .drive_status, .sect_num_out, .cyl_low_out, .cyl_high_out,
        .head_out, .power_saving_control, .low_power_idle_timeout, .low_speed_standby_timeout,
        .acoustic_seek_control_en, .acoustic_seek_control_quiet, .ident_max_28, .ident_max_48,
        .sec_op_pulse);
    pamc_host host (.core_clk, .cmd_done, .cmd_valid, .command_code, .feature_in,
        .sect_count_in, .sect_num_in, .cyl_low_in, .cyl_high_in, .device_head_select);
    // ====================
    // common tasks
    task chk(input string nm, input logic [47:0] s, input logic [47:0] e);
        checked++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task results;
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task go(input logic [7:0] c, f, n, input logic [27:0] a);
        logic ok;
        host.issue(c, f, n, a, ok);
        chk("cmd_done", ok, 1'b1);
    endtask
    task ab(input logic e);
        chk("abort_flag", error_flags[2], e);
        chk("error_status", drive_status[0], e);
    endtask
    // reset event pulse: bit2 power-on, bit1 hard, bit0 soft
    task ev(input logic [2:0] m);
        @(posedge core_clk) #1;
        {por_pulse, hard_rst_pulse, soft_rst_pulse} = m;
        @(posedge core_clk) #1;
        {por_pulse, hard_rst_pulse, soft_rst_pulse} = 3'h0;
    endtask
    // ====================
    // scenarios
    task t_pwr;
        chk("status", drive_status, 8'h50);
        chk("idle_init", low_power_idle_timeout, 13'h0078);
        go(8'hEF, 8'h05, 8'h90, 28'h0);
        chk("pwr", power_saving_control, 2'h1);
        chk("idle", low_power_idle_timeout, 13'h00C8);
        ab(1'b0);
        go(8'hEF, 8'h05, 8'hFF, 28'h0);
        ab(1'b1);
        go(8'hEF, 8'h05, 8'h00, 28'h0);
        ab(1'b1);
        go(8'hEF, 8'h05, 8'hBF, 28'h0);
        chk("idle_top", low_power_idle_timeout, 13'h01B3);
        go(8'hEF, 8'h05, 8'h7F, 28'h0);
        chk("pwr", power_saving_control, 2'h2);
        chk("stby_top", low_speed_standby_timeout, 13'h111C);
        chk("idle_kept", low_power_idle_timeout, 13'h01B3);
        go(8'hEF, 8'h05, 8'h20, 28'h0);
        chk("stby_fix", low_speed_standby_timeout, 13'h0258);
        go(8'hEF, 8'h05, 8'hC0, 28'h0);
        chk("pwr", power_saving_control, 2'h0);
        go(8'hEF, 8'h05, 8'h40, 28'h0);
        chk("idle_load", low_power_idle_timeout, 13'h0078);
        chk("stby_base", low_speed_standby_timeout, 13'h0258);
        go(8'hEF, 8'h85, 8'h00, 28'h0);
        chk("pwr", power_saving_control, 2'h0);
        go(8'hEF, 8'hFE, 8'h00, 28'h0);
        ab(1'b1);
    endtask
    task t_keep;
        go(8'hEF, 8'h05, 8'h90, 28'h0);
        go(8'hEF, 8'h42, 8'hA0, 28'h0);
        chk("quiet", acoustic_seek_control_quiet, 1'b1);
        go(8'hEF, 8'h42, 8'h7F, 28'h0);
        ab(1'b1);
        go(8'hEF, 8'h42, 8'hC0, 28'h0);
        chk("quiet", acoustic_seek_control_quiet, 1'b0);
        ev(3'h1);
        chk("pwr_soft", power_saving_control, 2'h1);
        ev(3'h2);
        chk("pwr_hard", power_saving_control, 2'h0);
        chk("idle_hard", low_power_idle_timeout, 13'h0078);
        go(8'hEF, 8'hCC, 8'h00, 28'h0);
        go(8'hEF, 8'h05, 8'h90, 28'h0);
        ev(3'h1);
        chk("pwr_revert", power_saving_control, 2'h0);
        ev(3'h4);
        chk("seek_en", acoustic_seek_control_en, 1'b1);
        chk("seek_quiet", acoustic_seek_control_quiet, 1'b0);
    endtask
    task t_max;
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        go(8'hF9, 8'h00, 8'h00, 28'h0123456);
        ab(1'b0);
        chk("ret", {head_out, cyl_high_out, cyl_low_out, sect_num_out}, 28'h0123456);
        chk("id28", ident_max_28, 28'h0123456);
        chk("id48", ident_max_48, 48'h0123456);
        access_lba = 48'h0123457;
        @(posedge core_clk) #1;
        chk("beyond", access_beyond_max, 1'b1);
        access_lba = 48'h0123456;
        @(posedge core_clk) #1;
        chk("beyond", access_beyond_max, 1'b0);
        go(8'hF9, 8'h01, 8'h00, 28'h0000100);
        chk("sec_op", sec_op_pulse, 3'h1);
        chk("id48", ident_max_48, 48'h0123456);
        // geometry addressing: only the cylinder is taken
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        host.chs = 1'b1;
        go(8'hF9, 8'h00, 8'h00, 28'h0001200);
        host.chs = 1'b0;
        chk("ret_chs", {head_out, cyl_high_out, cyl_low_out, sect_num_out}, 28'hF00123F);
    endtask
    task t_sec;
        logic [2:0] op;
        logic e;
        for (int i = 0; i < 3; i++) begin
            op = (i == 0) ? 3'h2 : (i == 1) ? 3'h3 : 3'h4;
            e = (i != 1);
            go(8'hF9, {5'h00, op}, 8'h00, 28'h0);
            chk("sec_op", sec_op_pulse, op);
            go(8'hF8, 8'h00, 8'h00, 28'h0);
            go(8'hF9, 8'h00, 8'h00, 28'h0100000);
            ab(e);
        end
    endtask
    task t_nv;
        ev(3'h2);
        go(8'hEF, 8'h09, 8'h00, 28'h0);
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        go(8'hF9, 8'h00, 8'h01, 28'h0200000);
        ab(1'b1);
        go(8'hEF, 8'h89, 8'h00, 28'h0);
        for (int i = 0; i < 2; i++) begin
            go(8'hF8, 8'h00, 8'h00, 28'h0);
            go(8'hF9, 8'h00, 8'h01, 28'h0200000);
            ab(i == 1);
        end
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        go(8'hF9, 8'h00, 8'h00, 28'h0080000);
        chk("id48_vol", ident_max_48, 48'h0080000);
        ev(3'h4);
        chk("id48_nv", ident_max_48, 48'h0200000);
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        go(8'h37, 8'h00, 8'h00, 28'h0080000);
        go(8'hF8, 8'h00, 8'h00, 28'h0);
        go(8'hF9, 8'h00, 8'h00, 28'h0080000);
        ab(1'b1);
    endtask
    // ====================
    // clock, timeout and main sequence
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            results;
        end
    end
    initial begin
        rst_n = 1'b0;
        {por_pulse, hard_rst_pulse, soft_rst_pulse} = 3'h0;
        access_lba = 48'h0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_pwr;
        t_keep;
        t_max;
        t_sec;
        t_nv;
        results;
    end
endmodule
